// ==== core/jic_cross_if.sv ====
// Crossing signals from the test-clock logic to the core-clock logic
`timescale 1ns/1ns
interface jic_cross_if;
   import jic_pkg::*;
   logic [1:0]        pm_tog;
   logic              pulse_tog;
   logic              cfgio;
   logic [2*NPIN-1:0] upd;
   modport link (output pm_tog, output pulse_tog, output cfgio, output upd);
   modport core (input pm_tog, input pulse_tog, input cfgio, input upd);
endinterface

// ==== core/jic_pkg.sv ====
// Constants, opcodes and types shared by the boundary-scan identification and clamp block
package jic_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int IR_W    = 4;
   localparam int ID_W    = 32;
   localparam int NPIN    = 8;
   // Opcodes chosen for this block
   localparam logic [IR_W-1:0] OP_EXTEST   = 4'h0;
   localparam logic [IR_W-1:0] OP_SAMPLE   = 4'h5;
   localparam logic [IR_W-1:0] OP_IDCODE   = 4'h6;
   localparam logic [IR_W-1:0] OP_USERCODE = 4'h7;
   localparam logic [IR_W-1:0] OP_CLAMP    = 4'ha;
   localparam logic [IR_W-1:0] OP_HIGHZ    = 4'hb;
   localparam logic [IR_W-1:0] OP_CFG_IO   = 4'hc;
   localparam logic [IR_W-1:0] OP_PULSE    = 4'hd;
   localparam logic [IR_W-1:0] OP_BYPASS   = 4'hf;
   // Identification code, value arbitrary
   localparam logic [ID_W-1:0] IDCODE_VAL  = 32'h0000_1001;
   // User signature default before configuration
   localparam logic [ID_W-1:0] USIG_DFLT   = 32'hffff_ffff;
   // Reset value and capture pattern of the instruction register
   localparam logic [IR_W-1:0] IR_RST      = OP_IDCODE;
   localparam logic [IR_W-1:0] IR_CAP      = 4'h1;
   // Length of the restart pulse in ns, rounded up to core cycles
   localparam int PULSE_NS     = 100;
   localparam int CLK_NS       = 10;
   localparam int PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   // Pin modes handed from the link domain to the core domain
   typedef enum logic [1:0] {JIC_PM_FUNC, JIC_PM_UPD, JIC_PM_HIZ} jic_pm_t;
   typedef enum logic [3:0] {
      JIC_TLR, JIC_RTI, JIC_SEL_DR, JIC_CAP_DR, JIC_SH_DR, JIC_EX1_DR, JIC_PA_DR,
      JIC_EX2_DR, JIC_UPD_DR, JIC_SEL_IR, JIC_CAP_IR, JIC_SH_IR, JIC_EX1_IR,
      JIC_PA_IR, JIC_EX2_IR, JIC_UPD_IR
   } jic_tap_t;
endpackage

// ==== core/jic_sync3.sv ====
// Three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module jic_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output      logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } jic_sy_t;
   jic_sy_t st_ff;
   jic_sy_t nxt_st;
   ////////////////////////////////////////////////////////////////////////////////
   // Shift, and accept the value once stages two and three agree
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = din;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      if (st_ff.s2 == st_ff.s3) begin
         nxt_st.q = st_ff.s3;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign dout = st_ff.q;
endmodule // jic_sync3

// ==== core/jic_top.sv ====
// Boundary-scan test port with identification, clamp, high-impedance and configuration control
`timescale 1ns/1ns
module jic_top
   import jic_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            tck,
   input  wire logic            trst,
   input  wire logic            tms,
   input  wire logic            tdi,
   output      logic            tdo,
   output      logic            tdo_oe,
   input  wire logic            cfg_done,
   input  wire logic [ID_W-1:0] user_signature,
   input  wire logic            load_restart_n,
   input  wire logic            chip_wide_clear_n,
   input  wire logic            chip_wide_output_enable,
   input  wire logic            opt_inbuf_always_on,
   input  wire logic [NPIN-1:0] core_out,
   input  wire logic [NPIN-1:0] core_oe,
   input  wire logic [NPIN-1:0] pin_out_only,
   input  wire logic [NPIN-1:0] pin_weak_keep,
   input  wire logic [NPIN-1:0] pin_in,
   output      logic [NPIN-1:0] pin_out,
   output      logic [NPIN-1:0] pin_oe,
   output      logic [NPIN-1:0] pin_keep_en,
   output      logic [NPIN-1:0] core_in,
   output      logic            cfg_interrupt,
   output      logic            cfg_restart
);
   import jic_pkg::*;

   localparam int BSR_W = 3 * NPIN;
   localparam int PCW   = $clog2(PULSE_CYC + 1);

   jic_cross_if xif ();

   ////////////////////////////////////////////////////////////////////////////////
   // Test-clock domain state; reset by trst or power-on reset only
   typedef struct packed {
      jic_tap_t        tap;
      logic [IR_W-1:0] ir_sh;
      logic [IR_W-1:0] ir;
      logic [ID_W-1:0] id_sh;
      logic            byp;
      logic [BSR_W-1:0] bsr_sh;
      logic [BSR_W-1:0] bsr_upd;
      logic [1:0]      pm_tog;
      logic            pulse_tog;
      logic            cfgio;
   } jic_lk_t;
   jic_lk_t lk_ff;
   jic_lk_t nxt_lk;
   logic    tdo_ff;
   logic    tdo_oe_ff;
   logic    tck_rst;
   logic    ser_bit;
   logic    is_bsr;
   logic    is_id;
   logic    cfg_lk;

   assign tck_rst = rst | trst;

   // Configuration-done level brought into the test-clock domain
   // The test clock runs only during scans, so the level settles after four
   // rises; a scan issued straight after the change still reads the default
   jic_sync3 #(.W(1)) u_sync_cfg (
      .clk  (tck),
      .rst  (tck_rst),
      .din  (cfg_done),
      .dout (cfg_lk)
   );

   // Instruction decode; unknown codes fall back to bypass
   always_comb begin
      is_bsr = (lk_ff.ir == OP_SAMPLE) || (lk_ff.ir == OP_EXTEST);
      is_id  = (lk_ff.ir == OP_IDCODE) || (lk_ff.ir == OP_USERCODE);
   end

   // Serial path: bypass for clamp, high-impedance and unknown
   always_comb begin
      if (lk_ff.tap == JIC_SH_IR) begin
         ser_bit = lk_ff.ir_sh[0];
      end else if (is_id) begin
         ser_bit = lk_ff.id_sh[0];
      end else if (is_bsr) begin
         ser_bit = lk_ff.bsr_sh[0];
      end else begin
         ser_bit = lk_ff.byp;
      end
   end

   // TAP walk, capture, shift and update on rising test clock
   always_comb begin
      logic [ID_W-1:0] usig;
      usig   = USIG_DFLT;
      nxt_lk = lk_ff;
      // The signature is static once configuration is done, so the settled
      // done level is enough to qualify it
      if (cfg_lk) begin
         usig = user_signature;
      end
      unique case (lk_ff.tap)
         JIC_TLR:    nxt_lk.tap = tms ? JIC_TLR    : JIC_RTI;
         JIC_RTI:    nxt_lk.tap = tms ? JIC_SEL_DR : JIC_RTI;
         JIC_SEL_DR: nxt_lk.tap = tms ? JIC_SEL_IR : JIC_CAP_DR;
         JIC_CAP_DR: nxt_lk.tap = tms ? JIC_EX1_DR : JIC_SH_DR;
         JIC_SH_DR:  nxt_lk.tap = tms ? JIC_EX1_DR : JIC_SH_DR;
         JIC_EX1_DR: nxt_lk.tap = tms ? JIC_UPD_DR : JIC_PA_DR;
         JIC_PA_DR:  nxt_lk.tap = tms ? JIC_EX2_DR : JIC_PA_DR;
         JIC_EX2_DR: nxt_lk.tap = tms ? JIC_UPD_DR : JIC_SH_DR;
         JIC_UPD_DR: nxt_lk.tap = tms ? JIC_SEL_DR : JIC_RTI;
         JIC_SEL_IR: nxt_lk.tap = tms ? JIC_TLR    : JIC_CAP_IR;
         JIC_CAP_IR: nxt_lk.tap = tms ? JIC_EX1_IR : JIC_SH_IR;
         JIC_SH_IR:  nxt_lk.tap = tms ? JIC_EX1_IR : JIC_SH_IR;
         JIC_EX1_IR: nxt_lk.tap = tms ? JIC_UPD_IR : JIC_PA_IR;
         JIC_PA_IR:  nxt_lk.tap = tms ? JIC_EX2_IR : JIC_PA_IR;
         JIC_EX2_IR: nxt_lk.tap = tms ? JIC_UPD_IR : JIC_SH_IR;
         JIC_UPD_IR: nxt_lk.tap = tms ? JIC_SEL_DR : JIC_RTI;
      endcase
      unique case (lk_ff.tap)
         JIC_TLR: begin
            nxt_lk.ir    = IR_RST;
            nxt_lk.cfgio = 1'b0;
         end
         JIC_CAP_IR: nxt_lk.ir_sh = IR_CAP;
         JIC_SH_IR:  nxt_lk.ir_sh = {tdi, lk_ff.ir_sh[IR_W-1:1]};
         JIC_UPD_IR: begin
            nxt_lk.ir = lk_ff.ir_sh;
            // A new instruction ends high impedance or clamp at once
            if (lk_ff.ir_sh == OP_CFG_IO) begin
               nxt_lk.cfgio = 1'b1;
            end
            if (lk_ff.ir_sh == OP_PULSE) begin
               nxt_lk.cfgio     = 1'b0;
               nxt_lk.pulse_tog = ~lk_ff.pulse_tog;
            end
         end
         JIC_CAP_DR: begin
            nxt_lk.byp = 1'b0;
            if (lk_ff.ir == OP_IDCODE) begin
               nxt_lk.id_sh = IDCODE_VAL;
            end else if (lk_ff.ir == OP_USERCODE) begin
               nxt_lk.id_sh = usig;
            end
            if (is_bsr) begin
               nxt_lk.bsr_sh = {pin_oe, pin_out, core_in};
            end
         end
         JIC_SH_DR: begin
            nxt_lk.byp    = tdi;
            nxt_lk.id_sh  = {tdi, lk_ff.id_sh[ID_W-1:1]};
            nxt_lk.bsr_sh = {tdi, lk_ff.bsr_sh[BSR_W-1:1]};
         end
         JIC_UPD_DR: begin
            if (is_bsr) begin
               nxt_lk.bsr_upd = lk_ff.bsr_sh;
            end
         end
         default: ;
      endcase
      // Pin mode follows the instruction being loaded, so it changes on the
      // same edge as the instruction register; the test clock may stop after it
      unique case (nxt_lk.ir)
         OP_EXTEST, OP_CLAMP: nxt_lk.pm_tog = JIC_PM_UPD;
         OP_HIGHZ:            nxt_lk.pm_tog = JIC_PM_HIZ;
         default:             nxt_lk.pm_tog = JIC_PM_FUNC;
      endcase
   end

   always_ff @(posedge tck or posedge tck_rst) begin
      if (tck_rst) begin
         lk_ff <= '{tap: JIC_TLR, ir: IR_RST, default: '0};
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   // TDO driven only in shift states, updated on falling test clock
   always_ff @(negedge tck or posedge tck_rst) begin
      if (tck_rst) begin
         tdo_ff    <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else begin
         tdo_oe_ff <= (lk_ff.tap == JIC_SH_DR) || (lk_ff.tap == JIC_SH_IR);
         tdo_ff    <= ser_bit;
      end
   end
   assign tdo    = tdo_ff;
   assign tdo_oe = tdo_oe_ff;

   assign xif.pm_tog    = lk_ff.pm_tog;
   assign xif.pulse_tog = lk_ff.pulse_tog;
   assign xif.cfgio     = lk_ff.cfgio;
   assign xif.upd       = lk_ff.bsr_upd[BSR_W-1 -: 2*NPIN];

   ////////////////////////////////////////////////////////////////////////////////
   // Core-clock side: crossings of mode word, interrupt level and restart event
   logic [2*NPIN+3:0] sy_q;
   logic [NPIN+1:0]   pin_sy;
   // Update cells, restart toggle, interrupt level and mode cross as one word;
   // it is taken only once two samples agree, so its bits never mix
   jic_sync3 #(.W(2*NPIN+4)) u_sync (
      .clk  (clk),
      .rst  (rst),
      .din  ({xif.upd, xif.pulse_tog, xif.cfgio, xif.pm_tog}),
      .dout (sy_q)
   );

   // Pin levels; the restart pin is inverted so a reset reads as no request
   jic_sync3 #(.W(NPIN+2)) u_sync_pin (
      .clk  (clk),
      .rst  (rst),
      .din  ({~load_restart_n, cfg_done, pin_in}),
      .dout (pin_sy)
   );

   typedef struct packed {
      logic            pulse_seen;
      logic [PCW-1:0]  pcnt;
      logic            restart;
      logic            intr;
      logic [NPIN-1:0] pout;
      logic [NPIN-1:0] poe;
      logic [NPIN-1:0] keep;
      logic [NPIN-1:0] cin;
   } jic_cr_t;
   jic_cr_t cr_ff;
   jic_cr_t nxt_cr;
   jic_pm_t pm_core;
   logic [NPIN-1:0] upd_oe_n;
   logic [NPIN-1:0] upd_out;
   logic [NPIN-1:0] inbuf_on;

   // Update cells after the crossing; a one in an enable cell tri-states
   assign upd_oe_n = sy_q[NPIN+4 +: NPIN];
   assign upd_out  = sy_q[4 +: NPIN];

   always_comb begin
      pm_core  = jic_pm_t'(sy_q[1:0]);
      inbuf_on = ~pin_out_only | {NPIN{~pin_sy[NPIN] | opt_inbuf_always_on}};
      nxt_cr   = cr_ff;
      nxt_cr.pulse_seen = sy_q[3];
      // Interrupt configuration only when the setup instruction asks
      nxt_cr.intr = sy_q[2];
      // Restart pulse from the restart-load instruction
      if (sy_q[3] != cr_ff.pulse_seen) begin
         nxt_cr.pcnt = PCW'(PULSE_CYC);
      end else if (cr_ff.pcnt != '0) begin
         nxt_cr.pcnt = cr_ff.pcnt - PCW'(1);
      end
      nxt_cr.restart = (nxt_cr.pcnt != '0) | pin_sy[NPIN+1];
      // Chip-wide clear and output enable are not used by scan logic
      unique case (pm_core)
         JIC_PM_UPD: begin
            nxt_cr.pout = upd_out;
            nxt_cr.poe  = ~upd_oe_n;
         end
         JIC_PM_HIZ: begin
            nxt_cr.pout = '0;
            nxt_cr.poe  = '0;
         end
         default: begin
            nxt_cr.pout = core_out;
            nxt_cr.poe  = core_oe;
         end
      endcase
      // Weak keepers win over clamp or high impedance once configured
      nxt_cr.keep = pin_sy[NPIN] ? pin_weak_keep : '0;
      nxt_cr.cin  = pin_sy[NPIN-1:0] & inbuf_on;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cr_ff <= '0;
      end else begin
         cr_ff <= nxt_cr;
      end
   end

   assign pin_out       = cr_ff.pout;
   assign pin_oe        = cr_ff.poe;
   assign pin_keep_en   = cr_ff.keep;
   assign core_in       = cr_ff.cin;
   assign cfg_interrupt = cr_ff.intr;
   assign cfg_restart   = cr_ff.restart;
endmodule // jic_top

// ==== verif/jic_tester.sv ====
// Behavioural boundary-scan tester driving the four-wire link
`timescale 1ns/1ns
module jic_tester (
   output      logic tck,
   output      logic tms,
   output      logic tdi,
   output      logic trst,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   // Test clock stands low between frames, data idles at its pull-up level
   initial begin
      tck  = 1'b0;
      tms  = 1'b1;
      tdi  = 1'b1;
      trst = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // One 64 ns pulse: drive while low, take the output just before the rise
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #32;
      o   = tdo_oe ? tdo : 1'bx;
      tck = 1'b1;
      #32;
      tck = 1'b0;
      tdi = 1'b1;
   endtask
   // Asynchronous test reset, then park in run-test/idle
   task automatic tap_reset();
      logic o;
      trst = 1'b1;
      #64;
      trst = 1'b0;
      #32;
      step(1'b0, 1'b1, o);
   endtask
   // From idle to a shift state, n bits LSB first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic o;
      dout = '0;
      step(1'b1, 1'b1, o);
      if (ir) step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
      step(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
   endtask
endmodule // jic_tester

// ==== verif/jic_top_properties.sv ====
// Concurrent checks on the ports of the boundary-scan block
`timescale 1ns/1ns
module jic_top_properties
   import jic_pkg::*;
(
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            tck,
   input wire logic            trst,
   input wire logic            tdo,
   input wire logic            tdo_oe,
   input wire logic            load_restart_n,
   input wire logic            cfg_done,
   input wire logic [NPIN-1:0] pin_weak_keep,
   input wire logic [NPIN-1:0] pin_keep_en,
   input wire logic            cfg_interrupt,
   input wire logic            cfg_restart
);
   // All checks sample on the core clock
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // Serial output moves only on falling test-clock edges
   oe_edge_a: assert property ($changed(tdo_oe) |-> !tck)
      else $error("tdo_oe moved while tck high");
   tdo_edge_a: assert property ($changed(tdo) && tdo_oe |-> !tck)
      else $error("tdo moved while tck high");
   trst_quiet_a: assert property (trst |=> !tdo_oe)
      else $error("tdo_oe high during test reset");
   // Restart pin reaches the configuration restart
   restart_fall_a: assert property ($fell(load_restart_n) |-> ##[1:8] cfg_restart)
      else $error("restart pin not followed by cfg_restart");
   restart_hold_a: assert property ((!load_restart_n)[*8] |-> cfg_restart)
      else $error("cfg_restart low while restart pin held");
   // Keepers win only on a configured device; test reset clears the interrupt
   keep_on_a: assert property ((cfg_done && $stable(pin_weak_keep))[*6]
      |-> pin_keep_en == pin_weak_keep)
      else $error("keeper enable does not follow request");
   keep_off_a: assert property ((!cfg_done)[*6] |-> pin_keep_en == '0)
      else $error("keeper enabled before configuration");
   irq_clear_a: assert property ($rose(trst) |-> ##[1:10] !cfg_interrupt)
      else $error("cfg_interrupt not cleared by test reset");
endmodule // jic_top_properties

bind jic_top jic_top_properties u_jic_top_properties (
   .clk(clk), .rst(rst), .tck(tck), .trst(trst), .tdo(tdo), .tdo_oe(tdo_oe),
   .load_restart_n(load_restart_n), .cfg_done(cfg_done),
   .pin_weak_keep(pin_weak_keep), .pin_keep_en(pin_keep_en),
   .cfg_interrupt(cfg_interrupt), .cfg_restart(cfg_restart)
);

// ==== verif/jic_top_tb.sv ====
// Self-checking bench for the boundary-scan identification and clamp block
`timescale 1ns/1ns
module jic_top_tb;
   import jic_pkg::*;
   logic            clk, rst, tck, trst, tms, tdi, tdo, tdo_oe, cfg_done;
   logic            load_restart_n, chip_wide_clear_n, chip_wide_output_enable;
   logic            opt_inbuf_always_on, cfg_interrupt, cfg_restart;
   logic [ID_W-1:0] user_signature, dout;
   logic [NPIN-1:0] core_out, core_oe, pin_out_only, pin_weak_keep, pin_in;
   logic [NPIN-1:0] pin_out, pin_oe, pin_keep_en, core_in, upd_out;
   logic [IR_W-1:0] ir_m;
   int              n_fail, check_count, k;
   integer          seed;
   // Core clock, 10 ns
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   jic_top u_jic_top (.clk(clk), .rst(rst), .tck(tck), .trst(trst), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .cfg_done(cfg_done),
      .user_signature(user_signature), .load_restart_n(load_restart_n),
      .chip_wide_clear_n(chip_wide_clear_n),
      .chip_wide_output_enable(chip_wide_output_enable),
      .opt_inbuf_always_on(opt_inbuf_always_on), .core_out(core_out),
      .core_oe(core_oe), .pin_out_only(pin_out_only), .pin_weak_keep(pin_weak_keep),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_keep_en(pin_keep_en),
      .core_in(core_in), .cfg_interrupt(cfg_interrupt), .cfg_restart(cfg_restart));
   jic_tester u_jic_tester (.tck(tck), .tms(tms), .tdi(tdi), .trst(trst),
      .tdo(tdo), .tdo_oe(tdo_oe));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Fresh random core-side levels; chip-wide pins toggle to show they do nothing
   task automatic rnd_in();
      @(posedge clk);
      #1;
      user_signature = $random(seed);
      {core_out, core_oe, pin_in, pin_weak_keep} = $random(seed);
      pin_out_only = NPIN'($random(seed));
      {opt_inbuf_always_on, chip_wide_clear_n, chip_wide_output_enable} = 3'($random(seed));
   endtask
   // Load an instruction, check the capture pattern, let the pin mode cross
   task automatic set_ir(input logic [IR_W-1:0] op);
      rnd_in();
      u_jic_tester.scan(1'b1, IR_W, 32'(op), dout);
      chk("ir capture", dout, 32'(IR_CAP));
      ir_m = op;
      repeat (12) @(posedge clk);
      #1;
   endtask
   // Model of the selected path: code registers, else the one-bit bypass
   task automatic dr_check(input logic [31:0] din);
      logic [31:0] e;
      case (ir_m)
         OP_IDCODE:   e = IDCODE_VAL;
         OP_USERCODE: e = cfg_done ? user_signature : USIG_DFLT;
         default:     e = {din[30:0], 1'b0};
      endcase
      u_jic_tester.scan(1'b0, ID_W, din, dout);
      chk("data path", dout, e);
   endtask
   // Snapshot of the functional pins while preloading drive-enabled update cells
   task automatic bsr_check();
      logic [NPIN-1:0] inb;
      inb = cfg_done ? (~pin_out_only | {NPIN{opt_inbuf_always_on}}) : '1;
      u_jic_tester.scan(1'b0, 3 * NPIN, {16'h0, upd_out, 8'h0}, dout);
      chk("sample", dout, {8'h0, core_oe, core_out, pin_in & inb});
      chk("core in", 32'(core_in), 32'(pin_in & inb));
   endtask
   // Cuts a hang short, well beyond the roughly 34 us the sequence needs
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
   // Main sequence: unconfigured, configuring, configured
   initial begin
      seed = 79;
      n_fail = 0;
      check_count = 0;
      {user_signature, core_out, core_oe, pin_in, pin_weak_keep, pin_out_only} = '0;
      {opt_inbuf_always_on, chip_wide_clear_n, chip_wide_output_enable} = 3'b010;
      rst = 1'b1;
      cfg_done = 1'b0;
      load_restart_n = 1'b0;
      ir_m = IR_RST;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      u_jic_tester.tap_reset();
      dr_check($random(seed));
      chk("restart held", 32'(cfg_restart), 32'h1);
      set_ir(OP_USERCODE);
      dr_check($random(seed));
      set_ir(4'h3);
      chk("func out", 32'(pin_out), 32'(core_out));
      chk("func oe", 32'(pin_oe), 32'(core_oe));
      dr_check($random(seed));
      set_ir(OP_HIGHZ);
      dr_check($random(seed));
      chk("highz oe", 32'(pin_oe), 32'h0);
      chk("no keeper", 32'(pin_keep_en), 32'h0);
      // Preload drive enabled (active-low bit) and a random level, then clamp
      set_ir(OP_SAMPLE);
      upd_out = NPIN'($random(seed));
      bsr_check();
      set_ir(OP_CLAMP);
      chk("clamp out", 32'(pin_out), 32'(upd_out));
      chk("clamp oe", 32'(pin_oe), 32'hff);
      dr_check($random(seed));
      set_ir(OP_BYPASS);
      dr_check($random(seed));
      // Configuration running: allowed instructions leave it alone
      load_restart_n = 1'b1;
      for (k = 0; k < 3; k++) begin
         set_ir(k == 0 ? OP_IDCODE : k == 1 ? OP_BYPASS : OP_SAMPLE);
         chk("no interrupt", 32'(cfg_interrupt), 32'h0);
         chk("no restart", 32'(cfg_restart), 32'h0);
      end
      set_ir(OP_CFG_IO);
      chk("interrupt", 32'(cfg_interrupt), 32'h1);
      rnd_in();
      u_jic_tester.scan(1'b1, IR_W, 32'(OP_PULSE), dout);
      for (k = 0; k < 30 && cfg_restart !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      chk("restart pulse", 32'(cfg_restart), 32'h1);
      repeat (PULSE_CYC + 2) @(posedge clk);
      #1;
      chk("restart end", 32'(cfg_restart), 32'h0);
      chk("interrupt off", 32'(cfg_interrupt), 32'h0);
      set_ir(OP_CFG_IO);
      u_jic_tester.tap_reset();
      ir_m = IR_RST;
      // Configured device: user value and keepers take over
      cfg_done = 1'b1;
      set_ir(OP_USERCODE);
      dr_check($random(seed));
      set_ir(OP_SAMPLE);
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         #1;
         opt_inbuf_always_on = k[0];
         upd_out = NPIN'($random(seed));
         bsr_check();
      end
      set_ir(OP_HIGHZ);
      chk("keeper", 32'(pin_keep_en), 32'(pin_weak_keep));
      load_restart_n = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk("restart pin", 32'(cfg_restart), 32'h1);
      load_restart_n = 1'b1;
      report_and_stop();
   end
endmodule // jic_top_tb
